// [design/sms_defines.vh]
// constants shared by the security supervisor design files
`ifndef SMS_DEFINES_VH
`define SMS_DEFINES_VH

// register offsets (byte addresses)
`define SMS_REG_STATUS      8'h00
`define SMS_REG_REP_LIMIT   8'h04
`define SMS_REG_DISCARDS    8'h08

// status register field positions
`define SMS_STAT_STATE_LSB  0
`define SMS_STAT_SESS_BIT   6
`define SMS_STAT_ROLE_BIT   7
`define SMS_STAT_FAIL_LSB   8
`define SMS_STAT_HARD_BIT   12

// reset value and fixed failure limit
`define SMS_REP_LIMIT_RST   4'h3
`define SMS_FAIL_LIMIT      4'h8

// command codes
`define SMS_CMD_AUTH        3'h0
`define SMS_CMD_CRYPTO      3'h1
`define SMS_CMD_KEYLOAD     3'h2
`define SMS_CMD_APPLOAD     3'h3
`define SMS_CMD_ZEROIZE     3'h4
`define SMS_CMD_LOGOUT      3'h5

// response status codes
`define SMS_RSP_OK          2'h0
`define SMS_RSP_DENY        2'h1
`define SMS_RSP_FAIL        2'h2

// timing: fixed transaction time, least time rounds up
`define SMS_CLK_PERIOD_NS   10
`define SMS_TXN_TIME_NS     640
`define SMS_TXN_CYCLES      ((`SMS_TXN_TIME_NS + `SMS_CLK_PERIOD_NS - 1) / `SMS_CLK_PERIOD_NS)

`endif

// [design/sms_rep_test.v]
// continuous repetition test on 8-byte random blocks
`timescale 1ns/100ps
`default_nettype none
`include "sms_defines.vh"
module sms_rep_test (
  input  wire        i_clk,
  input  wire        i_sys_rst,
  input  wire        i_restart,
  input  wire [3:0]  i_limit,
  input  wire [63:0] i_blk,
  input  wire        i_valid,
  output reg         o_use_q,
  output reg         o_discard_q,
  output reg         o_fail_q
);
  reg [63:0] saved_q;
  reg        have_q;
  reg [3:0]  run_q;
  wire       same = (i_blk == saved_q);
  wire [3:0] run_inc = run_q + 4'h1;

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      saved_q     <= 64'h0000_0000_0000_0000;
      have_q      <= 1'b0;
      run_q       <= 4'h0;
      o_use_q     <= 1'b0;
      o_discard_q <= 1'b0;
      o_fail_q    <= 1'b0;
    end else begin
      o_use_q     <= 1'b0;
      o_discard_q <= 1'b0;
      if (i_restart) begin
        have_q <= 1'b0;
        run_q  <= 4'h0;
      end else if (i_valid) begin
        if (!have_q) begin
          // first block after start-up is only the reference
          saved_q <= i_blk;
          have_q  <= 1'b1;
        end else if (same) begin
          o_discard_q <= 1'b1;
          run_q       <= run_inc;
          if (run_inc >= i_limit) begin
            o_fail_q <= 1'b1;
          end
        end else begin
          o_use_q <= 1'b1;
          run_q   <= 4'h0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [design/sms_supervisor.v]
// security supervisor: self-test gating, sessions, output gating
`timescale 1ns/100ps
`default_nettype none
`include "sms_defines.vh"
module sms_supervisor (
  input  wire        i_clk,
  input  wire        i_sys_rst,
  input  wire        i_rst_pin_n,
  input  wire        i_hard_err_nv,
  // register port
  input  wire [7:0]  i_reg_addr,
  input  wire [31:0] i_reg_wdata,
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  output reg  [31:0] o_reg_rdata,
  // self-test engine
  output reg         o_st_start,
  input  wire        i_st_done,
  input  wire        i_kat_ok,
  input  wire        i_integ_ok,
  // random sources
  input  wire [63:0] i_det_blk,
  input  wire        i_det_valid,
  input  wire [63:0] i_ent_blk,
  input  wire        i_ent_valid,
  output reg         o_det_use,
  output reg         o_det_req,
  output reg         o_ent_use,
  output reg         o_ent_req,
  input  wire [63:0] i_seed,
  input  wire [63:0] i_seed_key,
  input  wire        i_seed_valid,
  output reg         o_seed_ok,
  output reg         o_seed_reject,
  // terminal commands
  input  wire        i_cmd_valid,
  input  wire [2:0]  i_cmd_code,
  input  wire        i_cmd_role,
  // service engine
  output reg         o_eng_start,
  output reg  [2:0]  o_eng_code,
  output reg         o_crypto_en,
  input  wire        i_eng_done,
  input  wire        i_eng_ok,
  input  wire [7:0]  i_eng_data,
  // response path
  output reg         o_out_en,
  output reg         o_resp_valid,
  output reg  [1:0]  o_resp_status,
  output reg  [7:0]  o_resp_data,
  output reg         o_hard_burn
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [4:0] ST_TEST = 5'b00001;
  localparam [4:0] ST_IDLE = 5'b00010;
  localparam [4:0] ST_BUSY = 5'b00100;
  localparam [4:0] ST_SOFT = 5'b01000;
  localparam [4:0] ST_HARD = 5'b10000;
  // full-width copy so the count is cut to the counter width on purpose
  localparam [31:0] TXN_CYC_W = `SMS_TXN_CYCLES;
  localparam [7:0]  TXN_CYC   = TXN_CYC_W[7:0];

  // command needs an authenticated operator
  function needs_role;
    input [2:0] code;
    begin
      needs_role = (code == `SMS_CMD_CRYPTO) || (code == `SMS_CMD_KEYLOAD) ||
                   (code == `SMS_CMD_ZEROIZE);
    end
  endfunction

  // ----------------------------------------------------------------
  // reset pin and repetition tests
  // ----------------------------------------------------------------
  wire       pin_lvl;
  reg        pin_prev_q;
  reg  [4:0] st_q;
  reg  [4:0] st_d;
  reg  [3:0] rep_limit_q;
  reg        test_entry_q;
  wire       det_use;
  wire       det_disc;
  wire       det_fail;
  wire       ent_use;
  wire       ent_disc;
  wire       ent_fail;
  wire       pin_reset = pin_prev_q & ~pin_lvl;

  sms_sync3 u_pin (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   (i_rst_pin_n),
    .o_level_q (pin_lvl)
  );

  sms_rep_test u_det (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_restart   (test_entry_q),
    .i_limit     (rep_limit_q),
    .i_blk       (i_det_blk),
    .i_valid     (i_det_valid),
    .o_use_q     (det_use),
    .o_discard_q (det_disc),
    .o_fail_q    (det_fail)
  );

  sms_rep_test u_ent (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_restart   (test_entry_q),
    .i_limit     (rep_limit_q),
    .i_blk       (i_ent_blk),
    .i_valid     (i_ent_valid),
    .o_use_q     (ent_use),
    .o_discard_q (ent_disc),
    .o_fail_q    (ent_fail)
  );

  // ----------------------------------------------------------------
  // session and transaction state
  // ----------------------------------------------------------------
  reg        pend_q;
  reg  [2:0] pend_code_q;
  reg        pend_role_q;
  reg        sess_q;
  reg        role_q;
  reg  [3:0] fail_cnt_q;
  reg  [2:0] txn_code_q;
  reg        txn_deny_q;
  reg        eng_done_q;
  reg        eng_ok_q;
  reg  [7:0] eng_data_q;
  reg  [7:0] txn_cnt_q;
  reg        hard_q;
  reg  [15:0] disc_cnt_q;

  wire rep_fail  = det_fail | ent_fail;
  wire txn_end   = (st_q == ST_BUSY) && (txn_cnt_q >= TXN_CYC) && eng_done_q;
  wire auth_fail = txn_end && (txn_code_q == `SMS_CMD_AUTH) && !txn_deny_q && !eng_ok_q;
  wire app_fail  = txn_end && (txn_code_q == `SMS_CMD_APPLOAD) && !eng_ok_q;
  wire halt_now  = auth_fail && (fail_cnt_q + 4'h1 >= `SMS_FAIL_LIMIT);
  wire role_bad  = (pend_code_q == `SMS_CMD_AUTH) && sess_q && (pend_role_q != role_q);
  wire deny_now  = role_bad || (needs_role(pend_code_q) && !sess_q);
  wire dispatch  = (st_q == ST_IDLE) && pend_q;

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_TEST: begin
        if (i_st_done) begin
          st_d = (i_kat_ok && i_integ_ok) ? ST_IDLE : ST_SOFT;
        end
      end
      ST_IDLE: begin
        if (dispatch) begin
          st_d = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (txn_end) begin
          st_d = ST_IDLE;
        end
      end
      ST_SOFT: begin
        st_d = ST_SOFT;
      end
      ST_HARD: begin
        st_d = ST_HARD;
      end
      default: begin
        st_d = ST_SOFT;
      end
    endcase
    if (st_q != ST_HARD && st_q != ST_SOFT) begin
      if (pin_reset) begin
        st_d = ST_TEST;
      end
      if (rep_fail || app_fail) begin
        st_d = ST_SOFT;
      end
    end
    if (hard_q || halt_now) begin
      st_d = ST_HARD;
    end
  end

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q         <= ST_TEST;
      test_entry_q <= 1'b1;
      pin_prev_q   <= 1'b1;
      hard_q       <= 1'b0;
      o_hard_burn  <= 1'b0;
      o_st_start   <= 1'b0;
    end else begin
      st_q         <= st_d;
      pin_prev_q   <= pin_lvl;
      // stored hard-error flag re-read every cycle; cleared only by system reset
      hard_q       <= hard_q | i_hard_err_nv | halt_now;
      o_hard_burn  <= halt_now;
      test_entry_q <= (st_d == ST_TEST) && (st_q != ST_TEST);
      o_st_start   <= test_entry_q;
    end
  end

  // ----------------------------------------------------------------
  // command latch, sessions and fixed-time transactions
  // ----------------------------------------------------------------
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pend_q        <= 1'b0;
      pend_code_q   <= 3'h0;
      pend_role_q   <= 1'b0;
      sess_q        <= 1'b0;
      role_q        <= 1'b0;
      fail_cnt_q    <= 4'h0;
      txn_code_q    <= 3'h0;
      txn_deny_q    <= 1'b0;
      eng_done_q    <= 1'b0;
      eng_ok_q      <= 1'b0;
      eng_data_q    <= 8'h00;
      txn_cnt_q     <= 8'h00;
      o_eng_start   <= 1'b0;
      o_eng_code    <= 3'h0;
      o_crypto_en   <= 1'b0;
      o_out_en      <= 1'b0;
      o_resp_valid  <= 1'b0;
      o_resp_status <= `SMS_RSP_OK;
      o_resp_data   <= 8'h00;
    end else begin
      o_eng_start  <= 1'b0;
      o_resp_valid <= 1'b0;
      // command held while self-test runs, dropped while busy or in error
      if (i_cmd_valid && !pend_q && (st_q == ST_TEST || st_q == ST_IDLE)) begin
        pend_q      <= 1'b1;
        pend_code_q <= i_cmd_code;
        pend_role_q <= i_cmd_role;
      end
      if (dispatch) begin
        pend_q     <= 1'b0;
        txn_code_q <= pend_code_q;
        txn_deny_q <= deny_now;
        txn_cnt_q  <= 8'h00;
        eng_ok_q   <= 1'b0;
        eng_data_q <= 8'h00;
        // denied or logout requests never reach the engine
        eng_done_q <= deny_now || (pend_code_q == `SMS_CMD_LOGOUT);
        if (!deny_now && pend_code_q != `SMS_CMD_LOGOUT) begin
          o_eng_start <= 1'b1;
          o_eng_code  <= pend_code_q;
        end
        if (pend_code_q == `SMS_CMD_AUTH && !deny_now) begin
          role_q <= pend_role_q;
        end
      end
      if (st_q == ST_BUSY) begin
        if (txn_cnt_q < TXN_CYC) begin
          txn_cnt_q <= txn_cnt_q + 8'h01;
        end
        if (i_eng_done && !eng_done_q) begin
          eng_done_q <= 1'b1;
          eng_ok_q   <= i_eng_ok;
          eng_data_q <= i_eng_data;
        end
      end
      // crypto only inside a granted crypto transaction
      o_crypto_en <= (st_d == ST_BUSY) && (st_q == ST_BUSY || dispatch) &&
                     (dispatch ? (pend_code_q == `SMS_CMD_CRYPTO && !deny_now)
                               : (txn_code_q == `SMS_CMD_CRYPTO && !txn_deny_q));
      // path connected only for ordinary transactions, not zeroize
      o_out_en <= (st_d == ST_BUSY) &&
                  ((dispatch ? pend_code_q : txn_code_q) != `SMS_CMD_ZEROIZE);
      if (txn_end && st_d == ST_IDLE) begin
        o_resp_valid <= 1'b1;
        if (txn_deny_q) begin
          o_resp_status <= `SMS_RSP_DENY;
          o_resp_data   <= 8'h00;
        end else if (txn_code_q == `SMS_CMD_AUTH) begin
          // pass or fail only, no engine detail
          o_resp_status <= eng_ok_q ? `SMS_RSP_OK : `SMS_RSP_FAIL;
          o_resp_data   <= 8'h00;
        end else begin
          o_resp_status <= eng_ok_q || txn_code_q == `SMS_CMD_LOGOUT ? `SMS_RSP_OK : `SMS_RSP_FAIL;
          o_resp_data   <= eng_data_q;
        end
      end
      if (txn_end && !txn_deny_q && txn_code_q == `SMS_CMD_AUTH) begin
        if (eng_ok_q) begin
          sess_q     <= 1'b1;
          fail_cnt_q <= 4'h0;
        end else begin
          fail_cnt_q <= fail_cnt_q + 4'h1;
        end
      end
      if (txn_end && txn_code_q == `SMS_CMD_LOGOUT) begin
        sess_q <= 1'b0;
      end
      if (st_d == ST_TEST || st_d == ST_SOFT || st_d == ST_HARD) begin
        sess_q      <= 1'b0;
        o_crypto_en <= 1'b0;
        o_out_en    <= 1'b0;
        if (st_d != ST_TEST) begin
          pend_q <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // random block handling and seed check
  // ----------------------------------------------------------------
  wire svc_ok = (st_q != ST_SOFT) && (st_q != ST_HARD);

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_det_use     <= 1'b0;
      o_det_req     <= 1'b0;
      o_ent_use     <= 1'b0;
      o_ent_req     <= 1'b0;
      o_seed_ok     <= 1'b0;
      o_seed_reject <= 1'b0;
      disc_cnt_q    <= 16'h0000;
    end else begin
      o_det_use     <= det_use & svc_ok;
      o_ent_use     <= ent_use & svc_ok;
      o_det_req     <= det_disc & svc_ok;
      o_ent_req     <= ent_disc & svc_ok;
      o_seed_ok     <= i_seed_valid && svc_ok && (i_seed != i_seed_key);
      o_seed_reject <= i_seed_valid && svc_ok && (i_seed == i_seed_key);
      if ((det_disc || ent_disc) && disc_cnt_q != 16'hFFFF) begin
        disc_cnt_q <= disc_cnt_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rep_limit_q <= `SMS_REP_LIMIT_RST;
      o_reg_rdata <= 32'h0000_0000;
    end else begin
      if (i_reg_wr && i_reg_addr == `SMS_REG_REP_LIMIT) begin
        // zero would fail on the first match; hold at least one
        rep_limit_q <= (i_reg_wdata[3:0] == 4'h0) ? 4'h1 : i_reg_wdata[3:0];
      end
      o_reg_rdata <= 32'h0000_0000;
      if (i_reg_rd) begin
        case (i_reg_addr)
          `SMS_REG_STATUS: begin
            o_reg_rdata[`SMS_STAT_STATE_LSB +: 5]  <= st_q;
            o_reg_rdata[`SMS_STAT_SESS_BIT]        <= sess_q;
            o_reg_rdata[`SMS_STAT_ROLE_BIT]        <= role_q;
            o_reg_rdata[`SMS_STAT_FAIL_LSB +: 4]   <= fail_cnt_q;
            o_reg_rdata[`SMS_STAT_HARD_BIT]        <= hard_q;
          end
          `SMS_REG_REP_LIMIT: begin
            o_reg_rdata[3:0] <= rep_limit_q;
          end
          `SMS_REG_DISCARDS: begin
            o_reg_rdata[15:0] <= disc_cnt_q;
          end
          default: begin
            o_reg_rdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// [design/sms_sync3.v]
// three-flop input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module sms_sync3 (
  input  wire i_clk,
  input  wire i_sys_rst,
  input  wire i_async,
  output reg  o_level_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  // reset level is high: pin idles released
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s1_q      <= 1'b1;
      s2_q      <= 1'b1;
      s3_q      <= 1'b1;
      o_level_q <= 1'b1;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        o_level_q <= s3_q;
      end
    end
  end
endmodule
`default_nettype wire

// [test/sms_supervisor_monitor.sv]
// assertion checker on the security supervisor ports
`timescale 1ns/100ps
`default_nettype none
module sms_supervisor_monitor (
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        o_st_start,
  input wire logic        i_st_done,
  input wire logic        o_out_en,
  input wire logic        o_resp_valid,
  input wire logic [1:0]  o_resp_status,
  input wire logic        o_eng_start,
  input wire logic        o_crypto_en,
  input wire logic        o_hard_burn,
  input wire logic        i_ent_valid,
  input wire logic        o_ent_use,
  input wire logic        o_ent_req,
  input wire logic        o_det_use,
  input wire logic [63:0] i_seed,
  input wire logic [63:0] i_seed_key,
  input wire logic        i_seed_valid,
  input wire logic        o_seed_ok,
  input wire logic        o_seed_reject
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic       st_run_q, eng_seen_q, hard_q, mute_q;
  logic [7:0] gap_q;
  logic [3:0] fails_q;
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_run_q   <= 1'h0;
      eng_seen_q <= 1'h0;
      hard_q     <= 1'h0;
      mute_q     <= 1'h0;
      gap_q      <= 8'h00;
      fails_q    <= 4'h0;
    end else begin
      st_run_q   <= o_st_start | (st_run_q & ~i_st_done);
      eng_seen_q <= o_eng_start | (eng_seen_q & ~o_resp_valid);
      hard_q     <= hard_q | o_hard_burn;
      // slack so the last answer may still leave
      mute_q     <= hard_q;
      gap_q      <= o_eng_start ? 8'h00 : gap_q + {7'h00, gap_q != 8'hff};
      if (o_resp_valid && o_resp_status == 2'h2)
        fails_q <= fails_q + 4'h1;
      else if (o_resp_valid && o_resp_status == 2'h0)
        fails_q <= 4'h0;
    end
  end
  property p_st_quiet; st_run_q |-> !o_out_en && !o_resp_valid && !o_crypto_en; endproperty
  a_st_quiet: assert property (p_st_quiet) else $error("output open in self-test");
  property p_txn_time; (o_resp_valid && eng_seen_q) |-> gap_q >= 8'h3e; endproperty
  a_txn_time: assert property (p_txn_time) else $error("answer too early");
  property p_hard_mute; mute_q |-> !o_resp_valid && !o_eng_start && !o_out_en; endproperty
  a_hard_mute: assert property (p_hard_mute) else $error("answer after halt");
  property p_hard_idle; mute_q |-> !o_crypto_en && !o_ent_use && !o_det_use; endproperty
  a_hard_idle: assert property (p_hard_idle) else $error("service after halt");
  property p_ent_pair; (o_ent_use || o_ent_req) |-> $past(i_ent_valid, 2) && !(o_ent_use && o_ent_req); endproperty
  a_ent_pair: assert property (p_ent_pair) else $error("bad block verdict");
  property p_seed; i_seed_valid ##1 (o_seed_ok || o_seed_reject) |->
    o_seed_reject == ($past(i_seed) == $past(i_seed_key)); endproperty
  a_seed: assert property (p_seed) else $error("seed verdict wrong");
  property p_boot_test; $fell(i_sys_rst) |-> ##[0:3] o_st_start; endproperty
  a_boot_test: assert property (p_boot_test) else $error("no self-test start");
  property p_burn; o_hard_burn |-> fails_q >= 4'h7; endproperty
  a_burn: assert property (p_burn) else $error("halt too early");
  c_ok: cover property (o_resp_valid && o_resp_status == 2'h0);
  c_discard: cover property (o_ent_req);
  c_burn: cover property (o_hard_burn);
endmodule
bind sms_supervisor sms_supervisor_monitor u_mon (
  .i_clk, .i_sys_rst, .o_st_start, .i_st_done, .o_out_en, .o_resp_valid, .o_resp_status,
  .o_eng_start, .o_crypto_en, .o_hard_burn, .i_ent_valid, .o_ent_use, .o_ent_req, .o_det_use,
  .i_seed, .i_seed_key, .i_seed_valid, .o_seed_ok, .o_seed_reject
);
`default_nettype wire

// [test/sms_supervisor_tb.sv]
// self-checking bench for the security supervisor
`timescale 1ns/100ps
`default_nettype none
`include "sms_defines.vh"
module sms_supervisor_tb;
  logic        i_clk = 1'h0, i_sys_rst = 1'h1, i_hard_err_nv = 1'h0, i_kat_ok = 1'h1, i_integ_ok = 1'h1;
  logic [7:0]  i_reg_addr = 8'h00, i_eng_data = 8'h5a;
  logic [31:0] i_reg_wdata = 32'h0, rdata;
  logic        i_reg_wr = 1'h0, i_reg_rd = 1'h0, i_st_done = 1'h0, i_eng_done = 1'h0, i_eng_ok = 1'h1;
  logic [63:0] i_det_blk = 64'h0, i_ent_blk = 64'h0, i_seed = 64'h0, i_seed_key = 64'h0;
  logic        i_det_valid = 1'h0, i_ent_valid = 1'h0, i_seed_valid = 1'h0, eng_ok = 1'h1;
  logic [3:0]  st_sh_q = 4'h0, eng_sh_q = 4'h0;
  wire         i_cmd_valid, i_cmd_role, i_rst_pin_n;
  wire [2:0]   i_cmd_code, o_eng_code;
  wire [31:0]  o_reg_rdata;
  wire [1:0]   o_resp_status;
  wire [7:0]   o_resp_data;
  wire         o_st_start, o_det_use, o_det_req, o_ent_use, o_ent_req, o_seed_ok, o_seed_reject;
  wire         o_eng_start, o_crypto_en, o_out_en, o_resp_valid, o_hard_burn;
  int          failures = 0, check_count = 0;
  sms_supervisor uut (
    .i_clk, .i_sys_rst, .i_rst_pin_n, .i_hard_err_nv, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
    .i_reg_rd, .o_reg_rdata, .o_st_start, .i_st_done, .i_kat_ok, .i_integ_ok, .i_det_blk,
    .i_det_valid, .i_ent_blk, .i_ent_valid, .o_det_use, .o_det_req, .o_ent_use, .o_ent_req,
    .i_seed, .i_seed_key, .i_seed_valid, .o_seed_ok, .o_seed_reject, .i_cmd_valid, .i_cmd_code,
    .i_cmd_role, .o_eng_start, .o_eng_code, .o_crypto_en, .i_eng_done, .i_eng_ok, .i_eng_data,
    .o_out_en, .o_resp_valid, .o_resp_status, .o_resp_data, .o_hard_burn
  );
  sms_terminal_model term (
    .i_clk, .o_cmd_valid(i_cmd_valid), .o_cmd_code(i_cmd_code), .o_cmd_role(i_cmd_role),
    .o_rst_pin_n(i_rst_pin_n)
  );
  always #5 i_clk = ~i_clk;
  // ----------------------------------------
  // self-test and service engine stand-ins
  // ----------------------------------------
  always @(posedge i_clk) begin
    st_sh_q    <= {st_sh_q[2:0], o_st_start};
    eng_sh_q   <= {eng_sh_q[2:0], o_eng_start};
    i_st_done  <= st_sh_q[3];
    i_eng_done <= eng_sh_q[2];
    i_eng_ok   <= eng_ok;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task note(input string s);
    $display("test %s done", s);
  endtask
  task do_reset(input logic kat, input logic nv);
    @(posedge i_clk);
    i_kat_ok      <= kat;
    i_hard_err_nv <= nv;
    i_sys_rst     <= 1'h1;
    repeat (6) @(posedge i_clk);
    i_sys_rst     <= 1'h0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'h1;
    @(posedge i_clk);
    i_reg_wr    <= 1'h0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_rd   <= 1'h1;
    @(posedge i_clk);
    i_reg_rd   <= 1'h0;
    @(negedge i_clk);
    rdata = o_reg_rdata;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdata, e);
  endtask
  task st(input logic [31:0] m, input logic [31:0] e);
    rd(`SMS_REG_STATUS);
    chk(rdata & m, e);
  endtask
  task wait_state(input logic [4:0] e);
    int n;
    n = 0;
    do begin
      rd(`SMS_REG_STATUS);
      n++;
    end while (rdata[4:0] !== e && n < 40);
    chk({27'h0, rdata[4:0]}, {27'h0, e});
  endtask
  // e: 0-2 status, 3 no answer, 4 any answer, 5 unchecked
  task cmd(input logic [2:0] c, input logic r, input int e);
    int n;
    logic ce, oe;
    n = 0;
    ce = 1'h0;
    oe = 1'h0;
    repeat (2) @(posedge i_clk);
    term.send(c, r);
    while (o_resp_valid !== 1'h1 && n < 200) begin
      @(negedge i_clk);
      ce = ce | o_crypto_en;
      oe = oe | o_out_en;
      n++;
    end
    if (e < 5) chk({31'h0, o_resp_valid}, (e == 3) ? 32'h0 : 32'h1);
    if (e < 3) chk({30'h0, o_resp_status}, e);
    if (e < 3) chk({24'h0, o_resp_data},
                   (e == 0 && c != `SMS_CMD_AUTH && c != `SMS_CMD_LOGOUT) ? 32'h5a : 32'h0);
    if (e < 3) chk({30'h0, ce, oe}, {30'h0, c == `SMS_CMD_CRYPTO && e == 0, c != `SMS_CMD_ZEROIZE});
    if (e == 0 && c != `SMS_CMD_LOGOUT) chk({29'h0, o_eng_code}, {29'h0, c});
    @(negedge i_clk);
  endtask
  task blk(input logic det, input logic [63:0] d, input logic [1:0] e);
    @(posedge i_clk);
    if (det) begin
      i_det_blk   <= d;
      i_det_valid <= 1'h1;
    end else begin
      i_ent_blk   <= d;
      i_ent_valid <= 1'h1;
    end
    @(posedge i_clk);
    i_det_valid <= 1'h0;
    i_ent_valid <= 1'h0;
    i_det_blk   <= ~d;
    i_ent_blk   <= ~d;
    @(posedge i_clk);
    @(negedge i_clk);
    if (e != 2'h3) chk({30'h0, det ? {o_det_use, o_det_req} : {o_ent_use, o_ent_req}}, {30'h0, e});
  endtask
  task seed(input logic [63:0] s, input logic [63:0] k, input logic [1:0] e);
    @(posedge i_clk);
    i_seed       <= s;
    i_seed_key   <= k;
    i_seed_valid <= 1'h1;
    @(posedge i_clk);
    i_seed_valid <= 1'h0;
    @(negedge i_clk);
    chk({30'h0, o_seed_ok, o_seed_reject}, {30'h0, e});
  endtask
  initial begin
    #500_000;
    failures++;
    wrap_up();
  end
  initial begin
    do_reset(1'h1, 1'h0);
    cmd(`SMS_CMD_CRYPTO, 1'h0, 1);
    wait_state(5'h02);
    rdc(`SMS_REG_REP_LIMIT, 32'h0000_0003);
    rdc(`SMS_REG_DISCARDS, 32'h0000_0000);
    rdc(8'h0c, 32'h0000_0000);
    wr(`SMS_REG_REP_LIMIT, 32'h0000_0000);
    rdc(`SMS_REG_REP_LIMIT, 32'h0000_0001);
    wr(`SMS_REG_REP_LIMIT, 32'h0000_0003);
    note("registers");
    cmd(`SMS_CMD_AUTH, 1'h0, 0);
    st(32'h0000_00c0, 32'h0000_0040);
    cmd(`SMS_CMD_AUTH, 1'h1, 1);
    for (int k = 1; k < 4; k++) cmd(k[2:0], 1'h0, 0);
    cmd(`SMS_CMD_LOGOUT, 1'h0, 0);
    cmd(`SMS_CMD_ZEROIZE, 1'h0, 1);
    eng_ok = 1'h0;
    repeat (3) cmd(`SMS_CMD_AUTH, 1'h0, 2);
    st(32'h0000_0f00, 32'h0000_0300);
    eng_ok = 1'h1;
    cmd(`SMS_CMD_AUTH, 1'h0, 0);
    st(32'h0000_0f00, 32'h0000_0000);
    note("sessions");
    seed(64'h1234_5678_9abc_def0, 64'h1234_5678_9abc_def0, 2'h1);
    seed(64'h1234_5678_9abc_def0, 64'h0fed_cba9_8765_4321, 2'h2);
    term.pin_reset();
    wait_state(5'h01);
    wait_state(5'h02);
    st(32'h0000_0040, 32'h0000_0000);
    blk(1'h1, 64'h5555_aaaa_5555_aaaa, 2'h0);
    blk(1'h1, 64'h0123_4567_89ab_cdef, 2'h2);
    blk(1'h0, 64'h5555_aaaa_5555_aaaa, 2'h0);
    blk(1'h0, 64'h0123_4567_89ab_cdef, 2'h2);
    blk(1'h0, 64'h5555_aaaa_5555_aaaa, 2'h1);
    rdc(`SMS_REG_DISCARDS, 32'h0000_0001);
    blk(1'h1, 64'h5555_aaaa_5555_aaaa, 2'h1);
    blk(1'h0, 64'h5555_aaaa_5555_aaaa, 2'h1);
    blk(1'h0, 64'h5555_aaaa_5555_aaaa, 2'h3);
    wait_state(5'h08);
    cmd(`SMS_CMD_CRYPTO, 1'h0, 3);
    note("repetition");
    do_reset(1'h0, 1'h0);
    wait_state(5'h08);
    note("self-test failure");
    do_reset(1'h1, 1'h0);
    wait_state(5'h02);
    cmd(`SMS_CMD_AUTH, 1'h0, 0);
    eng_ok = 1'h0;
    cmd(`SMS_CMD_APPLOAD, 1'h0, 3);
    wait_state(5'h08);
    note("load check");
    do_reset(1'h1, 1'h0);
    wait_state(5'h02);
    st(32'h0000_0fc0, 32'h0000_0000);
    for (int k = 0; k < 8; k++) cmd(`SMS_CMD_AUTH, 1'h0, (k < 7) ? 2 : 5);
    wait_state(5'h10);
    cmd(`SMS_CMD_CRYPTO, 1'h0, 3);
    note("attempt limit");
    do_reset(1'h1, 1'h1);
    wait_state(5'h10);
    note("hard error");
    wrap_up();
  end
endmodule
`default_nettype wire

// [test/sms_terminal_model.sv]
// card terminal model: sends commands and pulses the reset pin
`timescale 1ns/100ps
`default_nettype none
module sms_terminal_model (
  input  wire logic       i_clk,
  output var  logic       o_cmd_valid,
  output var  logic [2:0] o_cmd_code,
  output var  logic       o_cmd_role,
  output var  logic       o_rst_pin_n
);
  initial begin
    o_cmd_valid = 1'h0;
    o_cmd_code  = 3'h7;
    o_cmd_role  = 1'h0;
    o_rst_pin_n = 1'h1;
  end
  task send(input logic [2:0] code, input logic role);
    @(posedge i_clk);
    o_cmd_valid <= 1'h1;
    o_cmd_code  <= code;
    o_cmd_role  <= role;
    @(posedge i_clk);
    o_cmd_valid <= 1'h0;
    // idle lines flip so a stale copy is never trusted
    o_cmd_code  <= ~code;
    o_cmd_role  <= ~role;
  endtask
  task pin_reset;
    @(posedge i_clk);
    o_rst_pin_n <= 1'h0;
    repeat (4) @(posedge i_clk);
    o_rst_pin_n <= 1'h1;
  endtask
endmodule
`default_nettype wire
